/* File: hw/wmsu_core.sv */
// Word move and stack unit: APB registers, indirect resolve, memory sequencer.
// Assumes a single-cycle-acked word memory on mclk; ack is taken only while req is high.
//
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module wmsu_core
    import wmsu_pkg::*;
(
    input wire logic mclk, // 20 MHz clock
    input wire logic rst, // Async reset
    input wire logic ce, // Clock enable
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    output wmsu_memreq_t mem_o, // Memory request
    input wire logic [15:0] mem_rdata, // Memory read data
    input wire logic mem_ack // Memory accept
);
    logic pready_q, pslverr_q;
    logic [31:0] prdata_q;
    wmsu_memreq_t mem_q;
    wmsu_state_t state_q;
    wmsu_op_t op_q;
    logic [2:0] ctrl_op_q;
    logic ctrl_cond_q;
    wmsu_opnd_t opa_q, opb_q;
    logic [15:0] opc_q;
    logic [15:0] a_q, b_q, c_q, tgt_q, ptr_q, k_q, x0_q, x1_q, res_q;
    logic a_ind_q, b_ind_q, idx_q, pend_q;
    logic fault_q, zero_q, neg_q, done_q;

    wire apb_setup = psel && !penable;
    wire apb_wr = psel && penable && pready_q && pwrite;
    wire hit = (paddr == REG_CTRL) || (paddr == REG_STAT) || (paddr == REG_OPA)
               || (paddr == REG_OPB) || (paddr == REG_OPC);
    wire idle = (state_q == S_IDLE);
    wire wr_ctrl = apb_wr && (paddr == REG_CTRL);
    wire start = wr_ctrl && pwdata[CTRL_GO_BIT] && idle;
    wire done_clr = apb_wr && (paddr == REG_STAT) && pwdata[STAT_DONE_BIT];
    wire [31:0] stat_w = {27'h0, done_q, neg_q, zero_q, fault_q, !idle};
    wire [31:0] rd_mux = (paddr == REG_CTRL) ? {28'h0, ctrl_cond_q, ctrl_op_q}
                       : (paddr == REG_STAT) ? stat_w
                       : (paddr == REG_OPA) ? {15'h0, opa_q}
                       : (paddr == REG_OPB) ? {15'h0, opb_q}
                       : (paddr == REG_OPC) ? {16'h0, opc_q}
                       : 32'h0;

    // Control value decode
    wire [3:0] dig = c_q[15:12];
    wire c_ok = bcd_ok(c_q);
    wire [13:0] c_bin = bcd2bin(c_q);
    wire [13:0] len = bcd2bin({4'h0, c_q[11:0]});
    wire scatter_push = c_bin <= SCATTER_PUSH_MAX;
    wire is_sc = (op_q == OP_SCATTER);
    wire is_ga = (op_q == OP_GATHER);
    wire is_push = is_sc && !scatter_push && (dig == DIG_PUSH);
    wire is_fifo = is_ga && !scatter_push && (dig == DIG_FIFO);
    wire is_lifo = is_ga && !scatter_push && (dig == DIG_LIFO);
    wire is_pop = is_fifo || is_lifo;
    wire two_rd = (op_q == OP_SWAP) || (op_q == OP_BIT) || (op_q == OP_NIBBLE);

    wire sc_fault = !c_ok || (!scatter_push && (dig != DIG_PUSH))
                    || (scatter_push && span_bad(b_q, c_bin)) || (is_push && span_bad(b_q, len));
    wire ga_fault = !c_ok || (!scatter_push && (dig != DIG_FIFO) && (dig != DIG_LIFO))
                    || (scatter_push && span_bad(b_q, c_bin)) || (is_pop && span_bad(b_q, len));
    wire bit_fault = !c_ok || (bcd2bin({8'h0, c_q[7:0]}) > BIT_MAX)
                     || (bcd2bin({8'h0, c_q[15:8]}) > BIT_MAX);
    wire nib_fault = (c_q[3:0] > NIB_MAX) || (c_q[7:4] > NIB_MAX) || (c_q[11:8] > NIB_MAX);
    wire chk_fault = (op_q == OP_SCATTER) ? sc_fault
                   : (op_q == OP_GATHER) ? ga_fault
                   : (op_q == OP_BIT) ? bit_fault
                   : (op_q == OP_NIBBLE) ? nib_fault
                   : (op_q != OP_SWAP);

    // Full push and empty pop are refused rather than corrupting neighbours
    wire [15:0] len16 = {2'b00, len};
    wire ptr_bad = is_push ? (mem_rdata >= len16)
                 : ((mem_rdata > len16) || (mem_rdata == WORD_RST));

    // Indirect word resolve
    wire ind_need = idx_q ? b_ind_q : a_ind_q;
    wire [15:0] ind_src = idx_q ? b_q : a_q;
    wire [13:0] ind_bin = bcd2bin(mem_rdata);
    wire ind_bad = !bcd_ok(mem_rdata) || (ind_bin >= AREA_WORDS);
    wire [15:0] ind_addr = {ind_src[15:AREA_LSB], ind_bin[AREA_LSB-1:0]};
    logic [15:0] bit_res, nib_res;
    wmsu_calc u_calc (
        .src_w(x0_q),
        .dst_w(x1_q),
        .sel(c_q),
        .bit_res(bit_res),
        .nib_res(nib_res)
    );
    wire [15:0] b_plus1 = addr_add(b_q, 16'h0001);
    wire [15:0] rx0_addr = is_fifo ? b_plus1 : is_ga ? tgt_q : a_q;
    wire [15:0] wr0_addr = is_sc ? tgt_q : ((op_q == OP_BIT) || (op_q == OP_NIBBLE)) ? b_q : a_q;
    wire [15:0] wr0_data = (op_q == OP_SWAP) ? x1_q
                         : (op_q == OP_BIT) ? bit_res
                         : (op_q == OP_NIBBLE) ? nib_res
                         : x0_q;
    wire [15:0] wr1_data = (op_q == OP_SWAP) ? x0_q
                         : is_push ? addr_add(ptr_q, 16'h0001)
                         : addr_add(ptr_q, 16'hffff);
    wire [15:0] step_addr = (state_q == S_IND) ? ind_src
                          : (state_q == S_RPTR) ? b_q
                          : (state_q == S_RX0) ? rx0_addr
                          : (state_q == S_RX1) ? b_q
                          : (state_q == S_WR0) ? wr0_addr
                          : (state_q == S_SHR) ? addr_add(b_plus1, k_q)
                          : (state_q == S_SHW) ? addr_add(b_q, k_q)
                          : b_q;
    wire step_we = (state_q == S_WR0) || (state_q == S_WR1) || (state_q == S_SHW);
    wire [15:0] step_wdata = (state_q == S_WR0) ? wr0_data
                           : (state_q == S_WR1) ? wr1_data
                           : (state_q == S_SHW) ? x1_q
                           : WORD_RST;
    wire mem_state = (state_q != S_IDLE) && (state_q != S_CHK) && (state_q != S_FIN);
    wire mem_issue = mem_state && !mem_q.req && !((state_q == S_IND) && !ind_need);
    wire acc = mem_q.req && mem_ack;
    wire wr0_next_wr1 = (op_q == OP_SWAP) || is_push || is_pop;

    // APB slave, no wait states: pready is high in the first access cycle
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0;
        end else if (ce) begin
            pready_q <= apb_setup;
            pslverr_q <= apb_setup && !hit;
            prdata_q <= apb_setup ? rd_mux : prdata_q;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ctrl_op_q <= 3'h0;
            ctrl_cond_q <= 1'b0;
            opa_q <= '0;
            opb_q <= '0;
            opc_q <= WORD_RST;
        end else if (ce && apb_wr) begin
            if (paddr == REG_CTRL) begin
                ctrl_op_q <= pwdata[CTRL_OP_LSB +: 3];
                ctrl_cond_q <= pwdata[CTRL_COND_BIT];
            end else if (paddr == REG_OPA) begin
                opa_q <= pwdata[OPND_IND_BIT:0];
            end else if (paddr == REG_OPB) begin
                opb_q <= pwdata[OPND_IND_BIT:0];
            end else if (paddr == REG_OPC) begin
                opc_q <= pwdata[15:0];
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            mem_q <= '0;
        end else if (ce) begin
            if (acc) begin
                mem_q.req <= 1'b0;
                mem_q.we <= 1'b0;
            end else if (mem_issue) begin
                mem_q <= '{req: 1'b1, we: step_we, addr: step_addr, wdata: step_wdata};
            end
        end
    end

    // Done is sticky; a finish in the clearing cycle wins
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            done_q <= 1'b0;
        end else if (ce) begin
            done_q <= ((state_q == S_FIN) || (start && !pwdata[CTRL_COND_BIT])) || (done_q && !done_clr);
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            fault_q <= 1'b0;
            zero_q <= 1'b0;
            neg_q <= 1'b0;
        end else if (ce && (state_q == S_FIN)) begin
            fault_q <= pend_q;
            if (!pend_q && (is_sc || is_ga)) begin
                zero_q <= (x0_q == WORD_RST);
            end
            if (!pend_q && is_push) begin
                neg_q <= x0_q[15];
            end
            if (!pend_q && (op_q == OP_BIT)) begin
                neg_q <= res_q[15];
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_q <= S_IDLE;
            op_q <= OP_SWAP;
            a_q <= WORD_RST;
            b_q <= WORD_RST;
            a_ind_q <= 1'b0;
            b_ind_q <= 1'b0;
            c_q <= WORD_RST;
            idx_q <= 1'b0;
            tgt_q <= WORD_RST;
            ptr_q <= WORD_RST;
            k_q <= WORD_RST;
            x0_q <= WORD_RST;
            x1_q <= WORD_RST;
            res_q <= WORD_RST;
            pend_q <= 1'b0;
        end else if (ce) begin
            case (state_q)
                S_IDLE: begin
                    if (start && pwdata[CTRL_COND_BIT]) begin
                        op_q <= wmsu_op_t'(pwdata[CTRL_OP_LSB +: 3]);
                        {a_ind_q, a_q} <= opa_q;
                        {b_ind_q, b_q} <= opb_q;
                        c_q <= opc_q;
                        idx_q <= 1'b0;
                        pend_q <= 1'b0;
                        state_q <= S_IND;
                    end
                end
                S_IND: begin
                    if (!ind_need || acc) begin
                        if (ind_need && ind_bad) begin
                            pend_q <= 1'b1;
                            state_q <= S_FIN;
                        end else begin
                            if (ind_need && idx_q) begin
                                b_q <= ind_addr;
                            end
                            if (ind_need && !idx_q) begin
                                a_q <= ind_addr;
                            end
                            idx_q <= 1'b1;
                            state_q <= idx_q ? S_CHK : S_IND;
                        end
                    end
                end
                S_CHK: begin
                    tgt_q <= addr_add(b_q, {2'b00, c_bin});
                    pend_q <= chk_fault;
                    state_q <= chk_fault ? S_FIN : (is_push || is_pop) ? S_RPTR : S_RX0;
                end
                S_RPTR: begin
                    if (acc) begin
                        ptr_q <= mem_rdata;
                        tgt_q <= is_push ? addr_add(b_plus1, mem_rdata) : addr_add(b_q, mem_rdata);
                        pend_q <= ptr_bad;
                        state_q <= ptr_bad ? S_FIN : S_RX0;
                    end
                end
                S_RX0: begin
                    if (acc) begin
                        x0_q <= mem_rdata;
                        state_q <= two_rd ? S_RX1 : S_WR0;
                    end
                end
                S_RX1: begin
                    if (acc) begin
                        x1_q <= mem_rdata;
                        state_q <= S_WR0;
                    end
                end
                S_WR0: begin
                    if (acc) begin
                        res_q <= mem_q.wdata;
                        k_q <= 16'h0001;
                        state_q <= (is_fifo && (ptr_q > 16'h0001)) ? S_SHR : wr0_next_wr1 ? S_WR1 : S_FIN;
                    end
                end
                S_SHR: begin
                    if (acc) begin
                        x1_q <= mem_rdata;
                        state_q <= S_SHW;
                    end
                end
                S_SHW: begin
                    if (acc) begin
                        k_q <= addr_add(k_q, 16'h0001);
                        state_q <= (addr_add(k_q, 16'h0001) < ptr_q) ? S_SHR : S_WR1;
                    end
                end
                S_WR1: begin
                    if (acc) begin
                        state_q <= S_FIN;
                    end
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign mem_o = mem_q;
    property p_cond_off;
        @(posedge mclk) disable iff (rst || !ce)
        (start && !pwdata[CTRL_COND_BIT]) |=> idle && !mem_q.req && $stable(fault_q) && $stable(zero_q);
    endproperty
    a_cond_off: assert property (p_cond_off) else $error("operation ran with condition low");
    property p_swap_wr;
        @(posedge mclk) disable iff (rst || !ce)
        (mem_issue && (op_q == OP_SWAP) && (state_q == S_WR0)) |=> mem_q.we && (mem_q.wdata == x1_q)
            && (mem_q.addr == a_q);
    endproperty
    a_swap_wr: assert property (p_swap_wr) else $error("swap first write wrong");
    property p_push_ptr;
        @(posedge mclk) disable iff (rst || !ce)
        (mem_issue && is_push && (state_q == S_WR1)) |=> (mem_q.wdata == ptr_q + 16'h0001) && (mem_q.addr == b_q);
    endproperty
    a_push_ptr: assert property (p_push_ptr) else $error("push pointer not incremented");
    property p_pop_ptr;
        @(posedge mclk) disable iff (rst || !ce)
        (mem_issue && is_pop && (state_q == S_WR1)) |=> (mem_q.wdata == ptr_q - 16'h0001);
    endproperty
    a_pop_ptr: assert property (p_pop_ptr) else $error("pop pointer not decremented");
    property p_lifo_addr;
        @(posedge mclk) disable iff (rst || !ce)
        (mem_issue && is_lifo && (state_q == S_RX0)) |=> (mem_q.addr == b_q + ptr_q) && !mem_q.we;
    endproperty
    a_lifo_addr: assert property (p_lifo_addr) else $error("lifo reads wrong slot");
    property p_fifo_addr;
        @(posedge mclk) disable iff (rst || !ce)
        (mem_issue && is_fifo && (state_q == S_RX0)) |=> (mem_q.addr == b_q + 16'h0001);
    endproperty
    a_fifo_addr: assert property (p_fifo_addr) else $error("fifo reads wrong slot");
    property p_chk_fault;
        @(posedge mclk) disable iff (rst || !ce)
        ((state_q == S_CHK) && chk_fault) |=> (state_q == S_FIN) ##1 fault_q && idle && !mem_q.req;
    endproperty
    a_chk_fault: assert property (p_chk_fault) else $error("fault not reported or memory touched");
    property p_bit_fault;
        @(posedge mclk) disable iff (rst || !ce)
        ((state_q == S_CHK) && (op_q == OP_BIT) && (c_q[7:0] == 8'h16)) |=> ##1 fault_q;
    endproperty
    a_bit_fault: assert property (p_bit_fault) else $error("bit 16 accepted");
    property p_nib_fault;
        @(posedge mclk) disable iff (rst || !ce)
        ((state_q == S_CHK) && (op_q == OP_NIBBLE) && ((c_q[3:0] > NIB_MAX) || (c_q[11:8] > NIB_MAX)))
            |=> ##1 fault_q;
    endproperty
    a_nib_fault: assert property (p_nib_fault) else $error("bad digit selector accepted");
    property p_zero_flag;
        @(posedge mclk) disable iff (rst || !ce)
        ((state_q == S_FIN) && !pend_q && is_sc) |=> (zero_q == (x0_q == WORD_RST)) && !fault_q;
    endproperty
    a_zero_flag: assert property (p_zero_flag) else $error("scatter zero flag wrong");
    property p_neg_flag;
        @(posedge mclk) disable iff (rst || !ce)
        ((state_q == S_FIN) && !pend_q && (op_q == OP_BIT)) |=> (neg_q == res_q[15]);
    endproperty
    a_neg_flag: assert property (p_neg_flag) else $error("bit copy negative flag wrong");
endmodule
`default_nettype wire

/* File: hw/wmsu_pkg.sv */
// Shared constants, types and helpers of the word move and stack unit.
// Assumes a 20 MHz mclk, APB register access and a word memory port.
package wmsu_pkg;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STAT = 8'h04;
    localparam logic [7:0] REG_OPA = 8'h08;
    localparam logic [7:0] REG_OPB = 8'h0c;
    localparam logic [7:0] REG_OPC = 8'h10;
    localparam int CTRL_OP_LSB = 0;
    localparam int CTRL_COND_BIT = 3;
    localparam int CTRL_GO_BIT = 8;
    localparam int OPND_IND_BIT = 16;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_FAULT_BIT = 1;
    localparam int STAT_ZERO_BIT = 2;
    localparam int STAT_NEG_BIT = 3;
    localparam int STAT_DONE_BIT = 4;
    localparam int AREA_LSB = 12;
    localparam logic [13:0] AREA_WORDS = 14'h1000;
    localparam logic [13:0] SCATTER_PUSH_MAX = 14'h19ff;
    localparam logic [3:0] DIG_PUSH = 4'h9;
    localparam logic [3:0] DIG_FIFO = 4'h9;
    localparam logic [3:0] DIG_LIFO = 4'h8;
    localparam logic [13:0] BIT_MAX = 14'h000f;
    localparam logic [3:0] NIB_MAX = 4'h3;
    localparam logic [15:0] WORD_RST = 16'h0000;
    typedef enum logic [2:0] {OP_SWAP, OP_SCATTER, OP_GATHER, OP_BIT, OP_NIBBLE} wmsu_op_t;
    typedef enum logic [3:0] {S_IDLE, S_IND, S_CHK, S_RPTR, S_RX0, S_RX1,
                              S_WR0, S_SHR, S_SHW, S_WR1, S_FIN} wmsu_state_t;
    typedef struct packed {
        logic ind;
        logic [15:0] addr;
    } wmsu_opnd_t;
    typedef struct packed {
        logic req;
        logic we;
        logic [15:0] addr;
        logic [15:0] wdata;
    } wmsu_memreq_t;

    function automatic logic bcd_ok(input logic [15:0] v);
        bcd_ok = (v[15:12] <= 4'h9) && (v[11:8] <= 4'h9) && (v[7:4] <= 4'h9) && (v[3:0] <= 4'h9);
    endfunction

    function automatic logic [13:0] bcd2bin(input logic [15:0] v);
        bcd2bin = 14'(v[15:12]) * 14'd1000 + 14'(v[11:8]) * 14'd100 + 14'(v[7:4]) * 14'd10 + 14'(v[3:0]);
    endfunction

    function automatic logic [15:0] addr_add(input logic [15:0] base, input logic [15:0] off);
        addr_add = base + off;
    endfunction

    // Offset run leaves the area or wraps the address space
    function automatic logic span_bad(input logic [15:0] base, input logic [13:0] off);
        logic [16:0] s;
        s = {1'b0, base} + {3'b000, off};
        span_bad = s[16] || (s[15:AREA_LSB] != base[15:AREA_LSB]);
    endfunction
endpackage

/* File: hw/wmsu_calc.sv */
// Combinational bit and digit merge for the word move and stack unit.
// Assumes the selector has already been range checked by the caller.
`timescale 1ns/10ps
`default_nettype none
module wmsu_calc
    import wmsu_pkg::*;
(
    input wire logic [15:0] src_w, // Source word
    input wire logic [15:0] dst_w, // Old destination word
    input wire logic [15:0] sel, // BCD selector
    output logic [15:0] bit_res, // Destination after bit copy
    output logic [15:0] nib_res // Destination after digit copy
);
    logic [3:0] spos;
    logic [3:0] dpos;
    logic [1:0] si;
    logic [1:0] di;

    assign spos = 4'(sel[7:4] * 4'd10 + sel[3:0]);
    assign dpos = 4'(sel[15:12] * 4'd10 + sel[11:8]);

    always_comb begin
        bit_res = dst_w;
        bit_res[dpos] = src_w[spos];
    end

    always_comb begin
        si = 2'b00;
        di = 2'b00;
        nib_res = dst_w;
        for (int i = 0; i < 4; i++) begin
            si = 2'(sel[1:0] + 2'(i));
            di = 2'(sel[9:8] + 2'(i));
            if (i <= int'(sel[5:4])) begin
                nib_res[4*di +: 4] = src_w[4*si +: 4];
            end
        end
    end
endmodule
`default_nettype wire

/* File: test/wmsu_mem_model.sv */
// Behavioural word memory facing the unit's memory port.
// Assumes one request at a time; slow adds two wait cycles.
`timescale 1ns/10ps
`default_nettype none
module wmsu_mem_model
    import wmsu_pkg::*;
(
    input wire logic mclk, // Clock
    input wire logic rst, // Async reset
    input wire logic slow, // Add wait cycles
    input wire wmsu_memreq_t mem_i, // Request
    output logic [15:0] rdata, // Read data
    output logic ack // Accept pulse
);
    logic [15:0] m [0:65535];
    logic [1:0] wt_q;
    // Plain always: the bench also loads words directly
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            ack <= 1'b0;
            wt_q <= 2'h0;
            rdata <= 16'h0000;
        end else begin
            ack <= 1'b0;
            // Stale data toggles so a late sample cannot pass
            rdata <= ~rdata;
            if (mem_i.req && ack && mem_i.we) begin
                m[mem_i.addr] <= mem_i.wdata;
            end
            if (mem_i.req && !ack) begin
                if (slow && wt_q != 2'h2) begin
                    wt_q <= wt_q + 2'h1;
                end else begin
                    wt_q <= 2'h0;
                    ack <= 1'b1;
                    rdata <= mem_i.we ? ~rdata : m[mem_i.addr];
                end
            end
        end
    end
endmodule
`default_nettype wire

/* File: test/tb_word_move_stack_unit.sv */
// Bench for the word move and stack unit: APB tasks, memory model, flag checks.
// Assumes the memory model answers every request.
`timescale 1ns/10ps
`default_nettype none
module tb_word_move_stack_unit;
    import wmsu_pkg::*;
    typedef struct packed {logic [2:0] op; logic [16:0] a; logic [15:0] b; logic [15:0] c;} wmsu_case_t;
    logic mclk = 1'b0, rst = 1'b1, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0;
    logic pready, pslverr, mem_ack, serr;
    logic hold = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, st, rd;
    logic [2:0] f;
    logic [15:0] mem_rdata;
    wmsu_memreq_t mem_o;
    int fails = 0, compares = 0, cyc = 0;
    // Faulting cases: BCD, range, area split, pointer above length, bit, digit, indirect
    wmsu_case_t bad [8] = '{'{3'h1, 17'h30, 16'h100, 16'h7000}, '{3'h1, 17'h30, 16'h100, 16'h00a0},
        '{3'h1, 17'h30, 16'h0ffe, 16'h0005}, '{3'h2, 17'h40, 16'h100, 16'h7000},
        '{3'h2, 17'h40, 16'h250, 16'h8005}, '{3'h3, 17'h30, 16'h40, 16'h0016},
        '{3'h4, 17'h30, 16'h40, 16'h0004}, '{3'h0, 17'h10050, 16'h40, 16'h0000}};
    always #25 mclk = ~mclk;
    wmsu_core dut(.mclk(mclk), .rst(rst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .mem_o(mem_o), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
    wmsu_mem_model mem(.mclk(mclk), .rst(rst), .slow(slow), .mem_i(mem_o), .rdata(mem_rdata), .ack(mem_ack));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic run(input logic [2:0] op, input logic cnd, input logic [16:0] a, input logic [15:0] b,
                       input logic [15:0] c);
        int n;
        n = 0;
        apb(1'b1, REG_OPA, 32'(a));
        apb(1'b1, REG_OPB, 32'(b));
        apb(1'b1, REG_OPC, 32'(c));
        apb(1'b1, REG_CTRL, 32'(op) | (32'(cnd) << CTRL_COND_BIT) | (32'h1 << CTRL_GO_BIT));
        // Low clock enable must hold the started swap back
        if (hold) begin
            ce <= 1'b0;
            repeat (30) @(posedge mclk);
            chk(mem.m[16'h10], 16'h2222);
            ce <= 1'b1;
        end
        do begin
            apb(1'b0, REG_STAT, 32'h0);
            st = rd;
            n++;
        end while (st[STAT_DONE_BIT] !== 1'b1 && n < 100);
        if (st[STAT_DONE_BIT] !== 1'b1) fails++;
        apb(1'b1, REG_STAT, 32'h1 << STAT_DONE_BIT);
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 60000) begin
            fails++;
            give_verdict();
        end
    end
    initial begin
        mem.m[16'h10] = 16'h1111; mem.m[16'h20] = 16'h2222; mem.m[16'h30] = 16'h0000;
        mem.m[16'h31] = 16'habcd; mem.m[16'h32] = 16'h1234; mem.m[16'h200] = 16'h0000;
        mem.m[16'h250] = 16'h0006; mem.m[16'h303] = 16'h5a5a; mem.m[16'h50] = 16'h00fa;
        mem.m[16'h60] = 16'h0001; mem.m[16'h61] = 16'h0000; mem.m[16'h62] = 16'h4321;
        mem.m[16'h63] = 16'h0000; mem.m[16'h105] = 16'hffff; mem.m[16'h70] = 16'h0016;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        run(3'h0, 1'b1, 17'h10, 16'h20, 16'h0);
        chk(mem.m[16'h10], 16'h2222);
        chk(mem.m[16'h20], 16'h1111);
        run(3'h1, 1'b1, 17'h30, 16'h100, 16'h0005);
        chk(mem.m[16'h105], 16'h0000);
        chk(16'(st[STAT_ZERO_BIT]), 16'h1);
        f = st[3:1];
        run(3'h0, 1'b0, 17'h10, 16'h20, 16'h0);
        chk(mem.m[16'h10], 16'h2222);
        chk(16'(st[3:1]), 16'(f));
        hold <= 1'b1;
        run(3'h0, 1'b1, 17'h10070, 16'h20, 16'h0);
        hold <= 1'b0;
        chk(mem.m[16'h10], 16'h1111);
        chk(mem.m[16'h20], 16'h2222);
        slow <= 1'b1;
        run(3'h1, 1'b1, 17'h31, 16'h200, 16'h9010);
        chk(mem.m[16'h201], 16'habcd);
        chk(16'(st[STAT_ZERO_BIT]), 16'h0);
        run(3'h1, 1'b1, 17'h32, 16'h200, 16'h9010);
        chk(mem.m[16'h202], 16'h1234);
        chk(mem.m[16'h200], 16'h0002);
        run(3'h2, 1'b1, 17'h40, 16'h200, 16'h8010);
        chk(mem.m[16'h40], 16'h1234);
        chk(mem.m[16'h200], 16'h0001);
        run(3'h1, 1'b1, 17'h30, 16'h200, 16'h9010);
        run(3'h2, 1'b1, 17'h40, 16'h200, 16'h9010);
        chk(mem.m[16'h40], 16'habcd);
        chk(mem.m[16'h201], 16'h0000);
        chk(mem.m[16'h200], 16'h0001);
        run(3'h2, 1'b1, 17'h41, 16'h300, 16'h0003);
        chk(mem.m[16'h41], 16'h5a5a);
        chk(16'(st[STAT_ZERO_BIT]), 16'h0);
        slow <= 1'b0;
        run(3'h3, 1'b1, 17'h60, 16'h61, 16'h1500);
        chk(mem.m[16'h61], 16'h8000);
        chk(16'(st[STAT_NEG_BIT]), 16'h1);
        run(3'h4, 1'b1, 17'h62, 16'h63, 16'h0313);
        chk(mem.m[16'h63], 16'h4001);
        for (int i = 0; i < 8; i++) begin
            run(bad[i].op, 1'b1, bad[i].a, bad[i].b, bad[i].c);
            chk(16'(st[STAT_FAULT_BIT]), 16'h1);
            chk(mem.m[16'h40], 16'habcd);
        end
        apb(1'b0, 8'h20, 32'h0);
        chk(16'(serr), 16'h1);
        give_verdict();
    end
endmodule
`default_nettype wire
